// ===== hdl/mcic_top.sv
`timescale 1ns/1ps
`include "mcic_cfg.svh"
module mcic_top
  import mcic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic dcr_read_i,
  input wire logic dcr_write_i,
  input wire logic [9:0] dcr_addr_i,
  input wire logic [31:0] dcr_wr_data_i,
  output logic [31:0] dcr_rd_data_o,
  output logic dcr_ack_o,
  // crossbar request side
  input wire logic xbar_req_i,
  input wire mcic_cmd_t xbar_cmd_i,
  output logic xbar_ack_o,
  output logic xbar_err_o,
  // memory controller side
  input wire logic mem_addr_ready_in_i,
  input wire logic mem_rd_done_i,
  input wire logic mem_wr_done_i,
  output logic mem_cmd_valid_o,
  output mcic_cmd_t mem_cmd_addr_out_o,
  output logic row_conflict_out_o,
  output logic bank_conflict_out_o,
  // configuration seen by crossbar and controller
  output logic arb_prio_en_o,
  output logic clk_ratio_frac_o,
  output logic [1:0] burst_width_o,
  output logic [1:0] burst_len_o,
  output logic [3:0] write_data_delay_o
);

  function automatic logic [3:0] beats(input logic [1:0] code);
    beats = 4'h1 << code;
  endfunction

  function automatic logic masked_diff(input logic [0:31] a, input logic [0:31] b,
                                       input logic [0:31] m);
    masked_diff = |((a ^ b) & m);
  endfunction

  logic [0:31] ctrl_reg;
  logic [0:31] row_mask_reg;
  logic [0:31] bank_mask_reg;
  logic [31:0] rd_data_reg;
  logic ack_reg;
  mcic_state_t state_reg;
  mcic_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  mcic_cmd_t cmd_reg;
  mcic_cmd_t last_reg;
  logic last_valid_reg;
  logic rd_busy_reg;
  logic wr_busy_reg;
  logic xack_reg;
  logic xerr_reg;
  logic row_c_reg;
  logic bank_c_reg;

  // register decode
  wire sel_ctrl = dcr_addr_i == `MCIC_OFS_CONTROL;
  wire sel_row = dcr_addr_i == `MCIC_OFS_ROW_MASK;
  wire sel_bank = dcr_addr_i == `MCIC_OFS_BANK_MASK;
  wire sel_any = sel_ctrl | sel_row | sel_bank;
  wire wr_ctrl = dcr_write_i & sel_ctrl;
  wire [0:31] wr_word = dcr_wr_data_i;
  wire [3:0] wdd_new = wr_word[`MCIC_BIT_WDD_HI:`MCIC_BIT_WDD_LO];
  // reserved delay codes keep the old setting instead of reaching the controller
  wire wdd_ok = wdd_new <= `MCIC_WDD_MAX;
  wire [3:0] wdd_cur = ctrl_reg[`MCIC_BIT_WDD_HI:`MCIC_BIT_WDD_LO];
  wire [0:31] ctrl_wr_val = {wr_word[0:11], wdd_ok ? wdd_new : wdd_cur, wr_word[16:31]};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_reg :
                       sel_row ? row_mask_reg :
                       sel_bank ? bank_mask_reg : 32'h0000_0000;

  // configuration fields
  wire en = ctrl_reg[`MCIC_BIT_ENABLE];
  wire row_hold = ctrl_reg[`MCIC_BIT_ROW_HOLD];
  wire bank_hold = ctrl_reg[`MCIC_BIT_BANK_HOLD];
  wire dir_hold = ctrl_reg[`MCIC_BIT_DIR_HOLD];
  wire [1:0] hold_code = ctrl_reg[`MCIC_BIT_HOLD_DUR_HI:`MCIC_BIT_HOLD_DUR_LO];
  wire quad = ctrl_reg[`MCIC_BIT_QUAD];
  wire [1:0] len_code = ctrl_reg[`MCIC_BIT_LEN_HI:`MCIC_BIT_LEN_LO];
  wire pw_hold = ctrl_reg[`MCIC_BIT_PW_HOLD];
  wire pipe_rd = ctrl_reg[`MCIC_BIT_PIPE_RD];
  wire pipe_wr = ctrl_reg[`MCIC_BIT_PIPE_WR];
  wire [3:0] hold_cycles = {1'b0, `MCIC_HOLD_BASE} + {2'b00, hold_code};

  // admission of a new crossbar command
  wire blk_rd = ~pipe_rd & rd_busy_reg;
  wire blk_wr = (~pipe_wr & wr_busy_reg)
              | (~quad & rd_busy_reg);
  wire blocked = xbar_cmd_i.rnw ? blk_rd : blk_wr;
  wire take = xbar_req_i & en & ~blocked & (state_reg == MCIC_ST_IDLE);
  wire refuse = xbar_req_i & ~en;

  // conflict detection against the last command the controller took
  wire row_chg = last_valid_reg &
                 masked_diff(xbar_cmd_i.addr[0:31], last_reg.addr[0:31], row_mask_reg);
  wire bank_chg = last_valid_reg &
                  masked_diff(xbar_cmd_i.addr[0:31], last_reg.addr[0:31], bank_mask_reg);
  wire dir_chg = last_valid_reg & (xbar_cmd_i.rnw != last_reg.rnw);
  wire partial = ~xbar_cmd_i.rnw & ~(&xbar_cmd_i.be);
  wire trig = (row_hold & row_chg)
            | (bank_hold & bank_chg)
            | (dir_hold & dir_chg)
            | (pw_hold & partial);
  // the controller must be ready before a command counts as issued
  wire issued = (state_reg == MCIC_ST_ISSUE) & mem_addr_ready_in_i;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      MCIC_ST_IDLE: begin
        if (take & trig) begin
          state_next = MCIC_ST_HOLD;
          cnt_next = hold_cycles - 4'h1;
        end else if (take) begin
          state_next = MCIC_ST_ISSUE;
        end
      end
      MCIC_ST_HOLD: begin
        if (cnt_reg == 4'h0) begin
          state_next = MCIC_ST_ISSUE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      MCIC_ST_ISSUE: begin
        if (issued & ~quad) begin
          // idle for one burst so double rate data cannot collide
          state_next = MCIC_ST_GAP;
          cnt_next = beats(len_code) - 4'h1;
        end else if (issued) begin
          state_next = MCIC_ST_IDLE;
        end
      end
      MCIC_ST_GAP: begin
        if (cnt_reg == 4'h0) begin
          state_next = MCIC_ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 4'h1;
        end
      end
      default: begin
        state_next = MCIC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= `MCIC_RST_CONTROL;
      row_mask_reg <= `MCIC_RST_MASK;
      bank_mask_reg <= `MCIC_RST_MASK;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_wr_val;
    end else if (dcr_write_i & sel_row) begin
      row_mask_reg <= wr_word;
    end else if (dcr_write_i & sel_bank) begin
      bank_mask_reg <= wr_word;
    end
  end

  // unmapped addresses get no ack so another slave may answer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
    end else begin
      rd_data_reg <= dcr_read_i ? rd_mux : 32'h0000_0000;
      ack_reg <= (dcr_read_i | dcr_write_i) & sel_any;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= MCIC_ST_IDLE;
      cnt_reg <= 4'h0;
      cmd_reg <= '0;
      row_c_reg <= 1'b0;
      bank_c_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (take) begin
        cmd_reg <= xbar_cmd_i;
        row_c_reg <= row_chg;
        bank_c_reg <= bank_chg;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_reg <= '0;
      last_valid_reg <= 1'b0;
    end else if (issued) begin
      last_reg <= cmd_reg;
      last_valid_reg <= 1'b1;
    end
  end

  // a new issue outweighs a completion in the same cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_busy_reg <= 1'b0;
      wr_busy_reg <= 1'b0;
    end else begin
      rd_busy_reg <= (issued & cmd_reg.rnw) | (rd_busy_reg & ~mem_rd_done_i);
      wr_busy_reg <= (issued & ~cmd_reg.rnw) | (wr_busy_reg & ~mem_wr_done_i);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xack_reg <= 1'b0;
      xerr_reg <= 1'b0;
    end else begin
      xack_reg <= take;
      xerr_reg <= refuse;
    end
  end

  assign dcr_rd_data_o = rd_data_reg;
  assign dcr_ack_o = ack_reg;
  assign xbar_ack_o = xack_reg;
  assign xbar_err_o = xerr_reg;
  assign mem_cmd_valid_o = state_reg == MCIC_ST_ISSUE;
  assign mem_cmd_addr_out_o = cmd_reg;
  assign row_conflict_out_o = row_c_reg;
  assign bank_conflict_out_o = bank_c_reg;
  assign arb_prio_en_o = ctrl_reg[`MCIC_BIT_PRIO];
  assign clk_ratio_frac_o = ctrl_reg[`MCIC_BIT_RATIO];
  assign burst_width_o = ctrl_reg[`MCIC_BIT_WIDTH_HI:`MCIC_BIT_WIDTH_LO];
  assign burst_len_o = len_code;
  assign write_data_delay_o = wdd_cur;

endmodule

// ===== hdl/mcic_cfg.svh
// What this block does
// - disabled interface fails every crossbar access
// - row change with hold enabled waits
// - bank change with hold enabled waits
// - direction change with hold enabled waits
// - hold codes give 2, 3, 4, 5 cycles
// - ratio bit picks integer or 3/2 clock
// - double rate: idle one burst after each
// - quad rate: pending read never blocks write
// - width codes 128, 64, reserved, 32 bits
// - length codes give 1, 2, 4, 8 beats
// - write data delay 0 to 10 only
// - partial write hold on missing byte enables
// - priority bit switches first-level arbitration
// - pipelined read bit allows overlapping reads
// - pipelined write bit allows overlapping writes
// - row mask flags changed row bits
// - bank mask flags changed bank bits
`ifndef MCIC_CFG_SVH
`define MCIC_CFG_SVH
`define MCIC_OFS_CONTROL 10'h010
`define MCIC_OFS_ROW_MASK 10'h011
`define MCIC_OFS_BANK_MASK 10'h012
`define MCIC_RST_CONTROL 32'h0000_008F
`define MCIC_RST_MASK 32'h0000_0000
// field positions use big-endian numbering, bit 0 is the msb
`define MCIC_BIT_ENABLE 0
`define MCIC_BIT_ROW_HOLD 1
`define MCIC_BIT_BANK_HOLD 2
`define MCIC_BIT_DIR_HOLD 3
`define MCIC_BIT_HOLD_DUR_HI 4
`define MCIC_BIT_HOLD_DUR_LO 5
`define MCIC_BIT_RATIO 6
`define MCIC_BIT_QUAD 7
`define MCIC_BIT_WIDTH_HI 8
`define MCIC_BIT_WIDTH_LO 9
`define MCIC_BIT_LEN_HI 10
`define MCIC_BIT_LEN_LO 11
`define MCIC_BIT_WDD_HI 12
`define MCIC_BIT_WDD_LO 15
`define MCIC_BIT_PW_HOLD 16
`define MCIC_BIT_PRIO 24
`define MCIC_BIT_PIPE_RD 28
`define MCIC_BIT_PIPE_WR 29
`define MCIC_HOLD_BASE 3'h2
`define MCIC_WDD_MAX 4'hA
`endif

// ===== hdl/mcic_pkg.sv
package mcic_pkg;
  typedef struct packed {
    logic [0:35] addr;
    logic rnw;
    logic [15:0] be;
  } mcic_cmd_t;
  typedef enum logic [1:0] {
    MCIC_ST_IDLE,
    MCIC_ST_HOLD,
    MCIC_ST_ISSUE,
    MCIC_ST_GAP
  } mcic_state_t;
endpackage

// ===== verif/mcic_checker.sv
`timescale 1ns/1ps
module mcic_checker
  import mcic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // crossbar and controller side
  input wire logic xbar_req_i,
  input wire logic xbar_ack_o,
  input wire logic xbar_err_o,
  input wire logic mem_addr_ready_in_i,
  input wire logic mem_cmd_valid_o,
  input wire mcic_cmd_t mem_cmd_addr_out_o,
  input wire logic row_conflict_out_o,
  input wire logic bank_conflict_out_o,
  input wire logic [3:0] write_data_delay_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  a_err_cause: assert property (xbar_err_o |-> $past(xbar_req_i)) else $error("stray error");
  a_ack_not_err: assert property (xbar_ack_o |-> !xbar_err_o) else $error("ack with error");
  a_hold_bound: assert property (xbar_ack_o |-> ##[0:5] mem_cmd_valid_o) else $error("hold too long");
  a_cmd_stands: assert property (mem_cmd_valid_o && !mem_addr_ready_in_i |=> mem_cmd_valid_o &&
    $stable(mem_cmd_addr_out_o)) else $error("command dropped");
  a_one_accept: assert property (mem_cmd_valid_o && mem_addr_ready_in_i |=> !mem_cmd_valid_o)
    else $error("command repeated");
  a_conf_stand: assert property (mem_cmd_valid_o && $past(mem_cmd_valid_o) |->
    $stable({row_conflict_out_o, bank_conflict_out_o})) else $error("conflict moved");
  a_ack_cause: assert property (xbar_ack_o |-> $past(xbar_req_i)) else $error("stray ack");
  a_wdd_legal: assert property (write_data_delay_o <= 4'hA) else $error("reserved delay");
endmodule
bind mcic_top mcic_checker mcic_checker_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .xbar_req_i(xbar_req_i),
  .xbar_ack_o(xbar_ack_o), .xbar_err_o(xbar_err_o), .mem_addr_ready_in_i(mem_addr_ready_in_i),
  .mem_cmd_valid_o(mem_cmd_valid_o), .mem_cmd_addr_out_o(mem_cmd_addr_out_o),
  .row_conflict_out_o(row_conflict_out_o), .bank_conflict_out_o(bank_conflict_out_o),
  .write_data_delay_o(write_data_delay_o));

// ===== verif/mcic_mem_model.sv
`timescale 1ns/1ps
module mcic_mem_model
  import mcic_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // command side
  input wire logic cmd_valid_i,
  input wire mcic_cmd_t cmd_i,
  input wire logic [3:0] stall_i,
  output logic ready_o,
  output logic rd_done_o,
  output logic wr_done_o
);
  logic busy_reg;
  logic rnw_reg;
  logic [3:0] cnt_reg;
  wire fin = busy_reg && cnt_reg == 4'h0;
  // one command in flight only, so the bridge must wait
  assign ready_o = !busy_reg;
  assign rd_done_o = fin && rnw_reg;
  assign wr_done_o = fin && !rnw_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'h0;
      rnw_reg <= 1'h0;
      cnt_reg <= 4'h0;
    end else if (cmd_valid_i && ready_o) begin
      busy_reg <= 1'h1;
      rnw_reg <= cmd_i.rnw;
      cnt_reg <= stall_i;
    end else if (busy_reg) begin
      busy_reg <= !fin;
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// ===== verif/memory_ctrl_interface_config_bench.sv
`timescale 1ns/1ps
module memory_ctrl_interface_config_bench import mcic_pkg::*;;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic req = 1'h0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] stall = 4'h3;
  mcic_cmd_t xc = '0;
  mcic_cmd_t mc;
  logic [31:0] dq, q;
  logic dk, k, ack, err, vld, rdy, rdn, wdn, rowc, bankc, prio, frac;
  logic [1:0] bw, bl;
  logic [3:0] write_data_delay;
  int failures = 0;
  int checked = 0;
  mcic_top mcic_top_i (.sys_clk_i(clk), .rst_i(rst), .dcr_read_i(rd), .dcr_write_i(wr), .dcr_addr_i(adr),
    .dcr_wr_data_i(wd), .dcr_rd_data_o(dq), .dcr_ack_o(dk), .xbar_req_i(req), .xbar_cmd_i(xc), .xbar_ack_o(ack),
    .xbar_err_o(err), .mem_addr_ready_in_i(rdy), .mem_rd_done_i(rdn), .mem_wr_done_i(wdn), .mem_cmd_valid_o(vld),
    .mem_cmd_addr_out_o(mc), .row_conflict_out_o(rowc), .bank_conflict_out_o(bankc), .arb_prio_en_o(prio),
    .clk_ratio_frac_o(frac), .burst_width_o(bw), .burst_len_o(bl), .write_data_delay_o(write_data_delay));
  mcic_mem_model mcic_mem_model_i (.sys_clk_i(clk), .rst_i(rst), .cmd_valid_i(vld), .cmd_i(mc), .stall_i(stall),
    .ready_o(rdy), .rd_done_o(rdn), .wr_done_o(wdn));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", s, x, g);
    end
  endtask
  task dcr(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    rd <= 1'h0;
    wr <= 1'h0;
    // ack and read data stand for this one cycle, so look once they settle
    #1;
    q = dq;
    k = dk;
  endtask
  // xl: -2 refused, -1 latency not judged
  task cmd(input logic [35:0] a, input logic r, input logic [15:0] b, input int xl, input logic [1:0] xf);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'h1;
    xc <= '{a, r, b};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ack !== 1'h1 && err !== 1'h1 && n < 20);
    chk("refused", 32'(xl == -2), 32'(err));
    if (xl > -2) begin
      n = 0;
      // request is let go at the first edge after the ack was seen
      while (vld !== 1'h1 && n < 9) begin
        @(posedge clk);
        req <= 1'h0;
        #1;
        n++;
      end
      if (xl >= 0) chk("latency", xl, n);
      chk("conflict", 32'(xf), 32'({rowc, bankc}));
      chk("address", a[31:0], mc.addr[4:35]);
    end
    @(posedge clk);
    req <= 1'h0;
    repeat (12) @(posedge clk);
  endtask
  task t_reset;
    dcr(1'h0, 10'h010, 32'h0000_0000);
    chk("control", 32'h0000_008F, q);
    dcr(1'h0, 10'h012, 32'h0000_0000);
    chk("bank mask", 32'h0000_0000, q);
    dcr(1'h0, 10'h013, 32'h0000_0000);
    chk("unmapped ack", 32'h0000_0000, 32'(k));
    cmd(36'h0_0000_0000, 1'h1, 16'hFFFF, -2, 2'h0);
  endtask
  task t_fields;
    dcr(1'h1, 10'h010, 32'h82FA_008F);
    chk("fields", 32'h0000_03F5, 32'({frac, bw, bl, write_data_delay, prio}));
    dcr(1'h1, 10'h010, 32'h82FF_000F);
    dcr(1'h0, 10'h010, 32'h0000_0000);
    chk("control", 32'h82FA_000F, q);
    chk("priority", 32'h0000_0000, 32'(prio));
  endtask
  task t_hold;
    for (int c = 0; c < 4; c++) begin
      dcr(1'h1, 10'h010, 32'h9000_000F | (32'(c) << 26));
      cmd(36'h0_0000_0000, 1'h1, 16'hFFFF, -1, 2'h0);
      cmd(36'h0_0000_0000, 1'h0, 16'hFFFF, c + 2, 2'h0);
      cmd(36'h0_0000_0000, 1'h0, 16'hFFFF, 0, 2'h0);
    end
    dcr(1'h1, 10'h010, 32'h8000_800F);
    cmd(36'h0_0000_0000, 1'h0, 16'h7FFF, 2, 2'h0);
  endtask
  task t_conf;
    stall <= 4'h0;
    dcr(1'h1, 10'h011, 32'h0000_0001);
    dcr(1'h1, 10'h012, 32'h0000_0002);
    dcr(1'h1, 10'h010, 32'hE000_000F);
    cmd(36'h0_0000_0000, 1'h1, 16'hFFFF, 0, 2'h0);
    cmd(36'h0_0000_0010, 1'h1, 16'hFFFF, 2, 2'h2);
    cmd(36'h0_0000_0020, 1'h1, 16'hFFFF, 2, 2'h3);
    cmd(36'h0_0000_0020, 1'h1, 16'hFFFF, 0, 2'h0);
    cmd(36'h0_0000_0000, 1'h1, 16'hFFFF, 2, 2'h1);
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_fields();
    t_hold();
    t_conf();
    end_of_test();
  end
  initial begin
    #100_000;
    failures++;
    end_of_test();
  end
endmodule
